//--- pkg/expo_regs_pkg.sv
// constants for the test-pattern and exposure-loop register bank
package expo_regs_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int PIX_W = 10;
	localparam int LANES = 4;
	localparam int WEIGHT_FRAC = 7;
	localparam int EMA_SHIFT = 4;
	localparam int SUBSAMPLE = 4;
	// register addresses
	localparam logic [8:0] ADDR_PATTERN_CTRL = 9'h090;
	localparam logic [8:0] ADDR_PATTERN_LOWER_A = 9'h092;
	localparam logic [8:0] ADDR_PATTERN_LOWER_B = 9'h093;
	localparam logic [8:0] ADDR_TEST_SPARE_B = 9'h095;
	localparam logic [8:0] ADDR_PATTERN_UPPER = 9'h096;
	localparam logic [8:0] ADDR_TEST_SPARE_C = 9'h09a;
	localparam logic [8:0] ADDR_TEST_SPARE_D = 9'h09b;
	localparam logic [8:0] ADDR_LOOP_CTRL = 9'h0a0;
	localparam logic [8:0] ADDR_TARGET_LEVEL = 9'h0a1;
	localparam logic [8:0] ADDR_WEIGHT_RED = 9'h0a2;
	localparam logic [8:0] ADDR_WEIGHT_GREEN_A = 9'h0a3;
	localparam logic [8:0] ADDR_WEIGHT_GREEN_B = 9'h0a4;
	localparam logic [8:0] ADDR_WEIGHT_BLUE = 9'h0a5;
	// reset values
	localparam logic [15:0] RST_PATTERN_CTRL = 16'h0000;
	localparam logic [15:0] RST_PATTERN_LOWER_A = 16'h0100;
	localparam logic [15:0] RST_PATTERN_LOWER_B = 16'h0302;
	localparam logic [15:0] RST_TEST_SPARE_B = 16'h0706;
	localparam logic [15:0] RST_PATTERN_UPPER = 16'h0000;
	localparam logic [15:0] RST_TEST_SPARE_C = 16'h0000;
	localparam logic [15:0] RST_TEST_SPARE_D = 16'h0000;
	localparam logic [15:0] RST_LOOP_CTRL = 16'h0010;
	localparam logic [15:0] RST_TARGET_LEVEL = 16'h60b8;
	localparam logic [15:0] RST_WEIGHT = 16'h0080;
	// field positions
	localparam int BIT_INSERT_EN = 0;
	localparam int BIT_LOOP_EN = 0;
	localparam int BIT_RESTART = 1;
	localparam int BIT_FREEZE = 2;
	localparam int BIT_SUBSAMPLE = 3;
	localparam int BIT_AMP_PRI = 4;
	localparam int LOOP_CTRL_W = 5;
	localparam int TARGET_LSB = 0;
	localparam int CLIP_LSB = 10;
	localparam int CLIP_W = 4;
	localparam int UPPER_W = 2;
	localparam int LOWER_W = 8;
	localparam int WEIGHT_W = 10;
	localparam int GAIN_W = 2;
	localparam logic [1:0] GAIN_MAX = 2'h3;
	localparam logic [1:0] GAIN_MIN = 2'h0;
endpackage

//--- design/expo_regs.sv
// register bank with test-pattern insertion and exposure statistics loop
`timescale 1ns/1ps
module expo_regs
	import expo_regs_pkg::*;
(
	input wire logic sys_clk_in, // 40 MHz system clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic [8:0] reg_addr_in, // register address from control port
	input wire logic reg_wr_in, // write strobe
	input wire logic [15:0] reg_wdata_in, // write data
	output logic [15:0] reg_rdata_out, // read data, registered
	input wire logic [39:0] pix_data_in, // four lanes of 10-bit pixels, lane 0 low
	input wire logic pix_valid_in, // pixel beat valid
	input wire logic frame_end_in, // end of frame pulse
	output logic [39:0] pix_data_out, // lanes after pattern insertion
	output logic pix_valid_out, // output beat valid
	output logic [12:0] filt_level_out, // filtered weighted average
	output logic [3:0] clip_threshold_out, // 4-bit clip threshold field
	output logic [1:0] gain_stage1_out, // applied stage 1 gain
	output logic [1:0] gain_stage2_out // applied stage 2 gain
);
	logic [15:0] pat_ctrl_q, pat_ctrl_d, lower_a_q, lower_a_d, lower_b_q, lower_b_d;
	logic [15:0] spare_b_q, spare_b_d, spare_c_q, spare_c_d, spare_d_q, spare_d_d;
	logic [15:0] upper_q, upper_d, target_q, target_d;
	logic [4:0] loop_ctrl_q, loop_ctrl_d;
	logic [9:0] weight_q [LANES], weight_d [LANES];
	logic [15:0] rdata_d;
	logic restart_pulse;
	logic [8:0] addr_w [LANES];

	assign addr_w[0] = ADDR_WEIGHT_RED;
	assign addr_w[1] = ADDR_WEIGHT_GREEN_A;
	assign addr_w[2] = ADDR_WEIGHT_GREEN_B;
	assign addr_w[3] = ADDR_WEIGHT_BLUE;

	// register writes
	always_comb begin
		pat_ctrl_d = pat_ctrl_q;
		lower_a_d = lower_a_q;
		lower_b_d = lower_b_q;
		spare_b_d = spare_b_q;
		spare_c_d = spare_c_q;
		spare_d_d = spare_d_q;
		upper_d = upper_q;
		target_d = target_q;
		loop_ctrl_d = loop_ctrl_q;
		restart_pulse = 1'b0;
		for (int i = 0; i < LANES; i++) begin
			weight_d[i] = weight_q[i];
			if (reg_wr_in && reg_addr_in == addr_w[i]) begin
				weight_d[i] = reg_wdata_in[WEIGHT_W-1:0];
			end
		end
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				ADDR_PATTERN_CTRL: pat_ctrl_d = reg_wdata_in;
				ADDR_PATTERN_LOWER_A: lower_a_d = reg_wdata_in;
				ADDR_PATTERN_LOWER_B: lower_b_d = reg_wdata_in;
				ADDR_TEST_SPARE_B: spare_b_d = reg_wdata_in;
				ADDR_PATTERN_UPPER: upper_d = reg_wdata_in;
				ADDR_TEST_SPARE_C: spare_c_d = reg_wdata_in;
				ADDR_TEST_SPARE_D: spare_d_d = reg_wdata_in;
				ADDR_LOOP_CTRL: begin
					// restart bit is a write-one pulse
					loop_ctrl_d = reg_wdata_in[LOOP_CTRL_W-1:0] & ~(5'h01 << BIT_RESTART);
					restart_pulse = reg_wdata_in[BIT_RESTART];
				end
				ADDR_TARGET_LEVEL: target_d = {2'h0, reg_wdata_in[13:0]};
				default: ;
			endcase
		end
	end

	// register reads
	always_comb begin
		rdata_d = 16'h0000;
		for (int i = 0; i < LANES; i++) begin
			if (reg_addr_in == addr_w[i]) begin
				rdata_d = {6'h00, weight_q[i]};
			end
		end
		unique case (reg_addr_in)
			ADDR_PATTERN_CTRL: rdata_d = pat_ctrl_q;
			ADDR_PATTERN_LOWER_A: rdata_d = lower_a_q;
			ADDR_PATTERN_LOWER_B: rdata_d = lower_b_q;
			ADDR_TEST_SPARE_B: rdata_d = spare_b_q;
			ADDR_PATTERN_UPPER: rdata_d = upper_q;
			ADDR_TEST_SPARE_C: rdata_d = spare_c_q;
			ADDR_TEST_SPARE_D: rdata_d = spare_d_q;
			ADDR_LOOP_CTRL: rdata_d = {11'h000, loop_ctrl_q};
			ADDR_TARGET_LEVEL: rdata_d = target_q;
			default: ;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pat_ctrl_q <= RST_PATTERN_CTRL;
			lower_a_q <= RST_PATTERN_LOWER_A;
			lower_b_q <= RST_PATTERN_LOWER_B;
			spare_b_q <= RST_TEST_SPARE_B;
			spare_c_q <= RST_TEST_SPARE_C;
			spare_d_q <= RST_TEST_SPARE_D;
			upper_q <= RST_PATTERN_UPPER;
			target_q <= RST_TARGET_LEVEL;
			loop_ctrl_q <= RST_LOOP_CTRL[LOOP_CTRL_W-1:0];
			for (int i = 0; i < LANES; i++) begin
				weight_q[i] <= RST_WEIGHT[WEIGHT_W-1:0];
			end
			reg_rdata_out <= 16'h0000;
		end else begin
			pat_ctrl_q <= pat_ctrl_d;
			lower_a_q <= lower_a_d;
			lower_b_q <= lower_b_d;
			spare_b_q <= spare_b_d;
			spare_c_q <= spare_c_d;
			spare_d_q <= spare_d_d;
			upper_q <= upper_d;
			target_q <= target_d;
			loop_ctrl_q <= loop_ctrl_d;
			weight_q <= weight_d;
			reg_rdata_out <= rdata_d;
		end
	end

	// datapath and statistics per lane
	logic [39:0] pix_d;
	logic [12:0] scaled [LANES];
	logic [31:0] lower_all;
	logic [1:0] sub_cnt_q, sub_cnt_d;
	logic sample_en;

	assign lower_all = {lower_b_q, lower_a_q};
	assign sample_en = pix_valid_in && (!loop_ctrl_q[BIT_SUBSAMPLE] || sub_cnt_q == 2'h0);

	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [19:0] prod;
		logic [9:0] pattern;
		assign pattern = {upper_q[UPPER_W*g +: UPPER_W], lower_all[LOWER_W*g +: LOWER_W]};
		assign pix_d[PIX_W*g +: PIX_W] = pat_ctrl_q[BIT_INSERT_EN] ? pattern : pix_data_in[PIX_W*g +: PIX_W];
		assign prod = pix_data_in[PIX_W*g +: PIX_W] * weight_q[g];
		assign scaled[g] = prod[19:WEIGHT_FRAC];
	end

	// exposure filter and gain distribution
	logic [12:0] avg_q, avg_d;
	logic [14:0] beat_sum;
	logic signed [14:0] diff;
	logic [1:0] g1_d, g2_d;
	logic loop_run;

	assign beat_sum = 15'(scaled[0]) + 15'(scaled[1]) + 15'(scaled[2]) + 15'(scaled[3]);
	assign diff = $signed({2'b00, beat_sum[14:2]}) - $signed({2'b00, avg_q});
	// freeze stops filter and gain updates
	assign loop_run = loop_ctrl_q[BIT_LOOP_EN] && !loop_ctrl_q[BIT_FREEZE];

	always_comb begin
		avg_d = avg_q;
		g1_d = gain_stage1_out;
		g2_d = gain_stage2_out;
		sub_cnt_d = pix_valid_in ? sub_cnt_q + 2'h1 : sub_cnt_q;
		if (restart_pulse) begin
			avg_d = 13'h0000;
		end else if (loop_run && sample_en) begin
			avg_d = 13'($signed({2'b00, avg_q}) + (diff >>> EMA_SHIFT));
		end
		if (loop_run && frame_end_in) begin
			// priority of stage 1 against stage 2
			if (avg_q < {3'h0, target_q[9:0]}) begin
				if (loop_ctrl_q[BIT_AMP_PRI] ? g1_d != GAIN_MAX : g2_d == GAIN_MAX) begin
					g1_d = (g1_d != GAIN_MAX) ? g1_d + 2'h1 : g1_d;
				end else if (g2_d != GAIN_MAX) begin
					g2_d = g2_d + 2'h1;
				end
			end else if (avg_q > {3'h0, target_q[9:0]}) begin
				// stage 2 never steps below its floor
				if (loop_ctrl_q[BIT_AMP_PRI] ? g2_d != GAIN_MIN : (g1_d == GAIN_MIN && g2_d != GAIN_MIN)) begin
					g2_d = g2_d - 2'h1;
				end else if (g1_d != GAIN_MIN) begin
					g1_d = g1_d - 2'h1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			avg_q <= 13'h0000;
			sub_cnt_q <= 2'h0;
			gain_stage1_out <= GAIN_MIN;
			gain_stage2_out <= GAIN_MIN;
			pix_data_out <= 40'h00_0000_0000;
			pix_valid_out <= 1'b0;
		end else begin
			avg_q <= avg_d;
			sub_cnt_q <= sub_cnt_d;
			gain_stage1_out <= g1_d;
			gain_stage2_out <= g2_d;
			pix_data_out <= pix_d;
			pix_valid_out <= pix_valid_in;
		end
	end

	assign filt_level_out = avg_q;
	assign clip_threshold_out = target_q[CLIP_LSB +: CLIP_W];

	sequence s_ctrl_write(bit [15:0] v);
		reg_wr_in && reg_addr_in == ADDR_LOOP_CTRL && reg_wdata_in == v;
	endsequence

	sequence s_frozen_frame;
		loop_ctrl_q[BIT_FREEZE] && frame_end_in && !(reg_wr_in && reg_addr_in == ADDR_LOOP_CTRL);
	endsequence

	a_pattern_lane0: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		pat_ctrl_q[BIT_INSERT_EN] |=> pix_data_out[9:0] == {$past(upper_q[1:0]), $past(lower_a_q[7:0])})
		else $error("lane 0 pattern word wrong");
	a_pattern_lane3: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		pat_ctrl_q[BIT_INSERT_EN] |=> pix_data_out[39:30] == {$past(upper_q[7:6]), $past(lower_b_q[15:8])})
		else $error("lane 3 pattern word wrong");
	a_pixel_pass: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!pat_ctrl_q[BIT_INSERT_EN] |=> pix_data_out == $past(pix_data_in))
		else $error("pixels altered while insertion off");
	a_restart_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_ctrl_write(16'h0013) |=> avg_q == 13'h0000 && loop_ctrl_q == 5'h11 ##1 loop_ctrl_q[BIT_RESTART] == 1'b0)
		else $error("filter restart failed");
	a_freeze_gains: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_frozen_frame |=> $stable(gain_stage1_out) && $stable(gain_stage2_out))
		else $error("gains moved while frozen");
	a_freeze_filter: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		loop_ctrl_q[BIT_FREEZE] && !restart_pulse |=> $stable(avg_q))
		else $error("filter moved while frozen");
	a_subsample_skip: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		loop_ctrl_q[BIT_SUBSAMPLE] && pix_valid_in && sub_cnt_q != 2'h0 && !restart_pulse |=> $stable(avg_q))
		else $error("subsampled beat used");
	a_stage1_first: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		loop_run && frame_end_in && loop_ctrl_q[BIT_AMP_PRI] && gain_stage1_out != GAIN_MAX
		&& avg_q < {3'h0, target_q[9:0]} |=> gain_stage1_out == $past(gain_stage1_out) + 2'h1 && $stable(gain_stage2_out))
		else $error("stage 1 not favoured");
	a_clip_field: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		reg_wr_in && reg_addr_in == ADDR_TARGET_LEVEL |=> clip_threshold_out == $past(reg_wdata_in[13:10]))
		else $error("clip threshold not taken");
	a_weight_readback: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		reg_wr_in && reg_addr_in == ADDR_WEIGHT_RED ##1 reg_addr_in == ADDR_WEIGHT_RED && !reg_wr_in
		|=> reg_rdata_out == {6'h00, $past(reg_wdata_in[9:0], 2)})
		else $error("red weight readback wrong");
endmodule

//--- verification/expo_regs_tb.sv
// self-checking bench for the test-pattern and exposure register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
	import expo_regs_pkg::*;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [8:0] reg_addr_in = 9'h000;
	logic reg_wr_in = 1'b0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic [15:0] reg_rdata_out;
	logic [39:0] pix_data_in = 40'h0;
	logic pix_valid_in = 1'b0;
	logic frame_end_in = 1'b0;
	logic [39:0] pix_data_out;
	logic pix_valid_out;
	logic [12:0] filt_level_out;
	logic [3:0] clip_threshold_out;
	logic [1:0] gain_stage1_out;
	logic [1:0] gain_stage2_out;
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	localparam logic [39:0] FLAT = {4{10'h100}};

	expo_regs dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .pix_data_in(pix_data_in),
		.pix_valid_in(pix_valid_in), .frame_end_in(frame_end_in), .pix_data_out(pix_data_out),
		.pix_valid_out(pix_valid_out), .filt_level_out(filt_level_out), .clip_threshold_out(clip_threshold_out),
		.gain_stage1_out(gain_stage1_out), .gain_stage2_out(gain_stage2_out));

	initial begin
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// hang guard, run needs about 120 cycles
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wr_in <= 1'b1;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [8:0] a, input logic [15:0] e);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		#1 `CHK("reg_rdata_out", e, reg_rdata_out)
	endtask

	task automatic beat(input logic [39:0] d);
		@(posedge sys_clk_in);
		pix_valid_in <= 1'b1;
		pix_data_in <= d;
		@(posedge sys_clk_in);
		pix_valid_in <= 1'b0;
		#1;
	endtask

	task automatic fend();
		@(posedge sys_clk_in);
		frame_end_in <= 1'b1;
		@(posedge sys_clk_in);
		frame_end_in <= 1'b0;
		@(posedge sys_clk_in);
		#1;
	endtask

	task automatic test_regs();
		`CHK("clip_threshold_out", 4'h8, clip_threshold_out)
		`CHK("gain_stage1_out", 2'h0, gain_stage1_out)
		rd(ADDR_TEST_SPARE_B, 16'h0706);
		rd(ADDR_PATTERN_UPPER, 16'h0000);
		rd(ADDR_TEST_SPARE_D, 16'h0000);
		rd(ADDR_LOOP_CTRL, 16'h0010);
		rd(ADDR_TARGET_LEVEL, 16'h60b8);
		rd(ADDR_WEIGHT_RED, 16'h0080);
		rd(ADDR_WEIGHT_GREEN_A, 16'h0080);
		rd(ADDR_WEIGHT_GREEN_B, 16'h0080);
		wr(9'h1ff, 16'hffff);
		rd(9'h1ff, 16'h0000);
		wr(ADDR_TEST_SPARE_C, 16'h1234);
		rd(ADDR_TEST_SPARE_C, 16'h1234);
		wr(ADDR_TARGET_LEVEL, 16'hffff);
		rd(ADDR_TARGET_LEVEL, 16'h3fff);
		`CHK("clip_threshold_out", 4'hf, clip_threshold_out)
		wr(ADDR_TARGET_LEVEL, 16'h60b8);
		wr(ADDR_WEIGHT_RED, 16'hffff);
		rd(ADDR_WEIGHT_RED, 16'h03ff);
		wr(ADDR_WEIGHT_RED, 16'h0080);
		$display("register test done");
	endtask

	task automatic test_pattern();
		wr(ADDR_PATTERN_UPPER, 16'h00e4);
		rd(ADDR_PATTERN_UPPER, 16'h00e4);
		wr(ADDR_PATTERN_CTRL, 16'h0001);
		beat(40'h55_5555_5555);
		`CHK("pix_data_out", {10'h303, 10'h202, 10'h101, 10'h000}, pix_data_out)
		`CHK("pix_valid_out", 1'b1, pix_valid_out)
		wr(ADDR_PATTERN_CTRL, 16'h0000);
		beat(40'h55_5555_5555);
		`CHK("pix_data_out", 40'h55_5555_5555, pix_data_out)
		$display("pattern test done");
	endtask

	task automatic test_loop();
		wr(ADDR_LOOP_CTRL, 16'h0011);
		beat(FLAT);
		`CHK("filt_level_out", 13'h010, filt_level_out)
		beat(FLAT);
		`CHK("filt_level_out", 13'h01f, filt_level_out)
		wr(ADDR_LOOP_CTRL, 16'h0015);
		beat(FLAT);
		fend();
		`CHK("filt_level_out", 13'h01f, filt_level_out)
		`CHK("gain_stage1_out", 2'h0, gain_stage1_out)
		wr(ADDR_LOOP_CTRL, 16'h0011);
		fend();
		`CHK("gain_stage1_out", 2'h1, gain_stage1_out)
		`CHK("gain_stage2_out", 2'h0, gain_stage2_out)
		wr(ADDR_LOOP_CTRL, 16'h0001);
		fend();
		`CHK("gain_stage2_out", 2'h1, gain_stage2_out)
		wr(ADDR_LOOP_CTRL, 16'h0013);
		@(posedge sys_clk_in);
		#1 `CHK("filt_level_out", 13'h000, filt_level_out)
		rd(ADDR_LOOP_CTRL, 16'h0011);
		wr(ADDR_WEIGHT_RED, 16'h0100);
		wr(ADDR_WEIGHT_GREEN_A, 16'h0000);
		wr(ADDR_WEIGHT_GREEN_B, 16'h0080);
		wr(ADDR_WEIGHT_BLUE, 16'h0000);
		beat(FLAT);
		`CHK("filt_level_out", 13'h00c, filt_level_out)
		// four beats with subsampling give one step
		wr(ADDR_LOOP_CTRL, 16'h0019);
		repeat (4) beat(FLAT);
		`CHK("filt_level_out", 13'h017, filt_level_out)
		// level above target lowers gains
		wr(ADDR_TARGET_LEVEL, 16'h0000);
		fend();
		`CHK("gain_stage2_out", 2'h0, gain_stage2_out)
		`CHK("gain_stage1_out", 2'h1, gain_stage1_out)
		wr(ADDR_LOOP_CTRL, 16'h0001);
		fend();
		`CHK("gain_stage1_out", 2'h0, gain_stage1_out)
		fend();
		`CHK("gain_stage2_out", 2'h0, gain_stage2_out)
		`CHK("gain_stage1_out", 2'h0, gain_stage1_out)
		$display("exposure loop test done");
	endtask

	initial begin
		repeat (10) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		@(posedge sys_clk_in);
		#1;
		test_regs();
		test_pattern();
		test_loop();
		print_verdict();
	end
endmodule
